// ==== design/hltm_pkg.sv ====
package hltm_pkg;

    localparam int CNT_W = 8;
    localparam int MODE_W = 5;
    localparam int VAR_W = 3;
    localparam int CLASS_LSB = 3;
    localparam int HOLD_W = 2;

    // Mode class, upper two bits of the mode field.
    typedef enum logic [1:0] {
        HLTM_CLS_FREE = 2'b00,
        HLTM_CLS_ONESHOT = 2'b01,
        HLTM_CLS_MONO = 2'b10,
        HLTM_CLS_RSVD = 2'b11
    } hltm_class_type;

    // Variant codes, lower three bits of the mode field.
    localparam logic [VAR_W-1:0] VAR_0 = 3'h0;
    localparam logic [VAR_W-1:0] VAR_1 = 3'h1;
    localparam logic [VAR_W-1:0] VAR_2 = 3'h2;
    localparam logic [VAR_W-1:0] VAR_3 = 3'h3;
    localparam logic [VAR_W-1:0] VAR_4 = 3'h4;
    localparam logic [VAR_W-1:0] VAR_5 = 3'h5;
    localparam logic [VAR_W-1:0] VAR_6 = 3'h6;
    localparam logic [VAR_W-1:0] VAR_7 = 3'h7;

    localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;
    localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
    // Extra timer clocks the count stays at zero after an edge reset.
    localparam logic [HOLD_W-1:0] HOLD_TICKS = 2'h1;
    localparam logic [HOLD_W-1:0] HOLD_NONE = 2'h0;
    localparam logic [HOLD_W-1:0] HOLD_ONE = 2'h1;

endpackage : hltm_pkg

// ==== design/hltm_sync_if.sv ====
`timescale 1ns/1ps
interface hltm_sync_if;
    logic ext_lvl;
    logic ext_rise;
    logic ext_fall;
    logic run_lvl;

    modport src (output ext_lvl, output ext_rise, output ext_fall, output run_lvl);
    modport dst (input ext_lvl, input ext_rise, input ext_fall, input run_lvl);
endinterface : hltm_sync_if

// ==== design/hltm_sync.sv ====
`timescale 1ns/1ps
module hltm_sync (
    input wire logic clk, // System clock.
    input wire logic rst, // Asynchronous reset, active high.
    input wire logic tick, // Timer clock enable.
    input wire logic ext_in, // Raw external reset signal.
    input wire logic run_in, // Run bit from the control register.
    hltm_sync_if.src sif // Synchronised levels and edges.
);

    logic ext_m_r, ext_s_r, ext_d_r, run_m_r, run_s_r;
    logic ext_m_nxt, ext_s_nxt, ext_d_nxt, run_m_nxt, run_s_nxt;

    // ****************************************
    // Two-stage synchronisers on the timer clock
    // ****************************************
    always_comb begin
        ext_m_nxt = ext_m_r;
        ext_s_nxt = ext_s_r;
        ext_d_nxt = ext_d_r;
        run_m_nxt = run_m_r;
        run_s_nxt = run_s_r;
        if (tick) begin
            ext_m_nxt = ext_in;
            ext_s_nxt = ext_m_r;
            ext_d_nxt = ext_s_r;
            run_m_nxt = run_in;
            run_s_nxt = run_m_r;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ext_m_r <= 1'b0;
            ext_s_r <= 1'b0;
            ext_d_r <= 1'b0;
            run_m_r <= 1'b0;
            run_s_r <= 1'b0;
        end else begin
            ext_m_r <= ext_m_nxt;
            ext_s_r <= ext_s_nxt;
            ext_d_r <= ext_d_nxt;
            run_m_r <= run_m_nxt;
            run_s_r <= run_s_nxt;
        end
    end

    // Edges last one timer clock, so each is seen on exactly one tick.
    assign sif.ext_lvl = ext_s_r;
    assign sif.ext_rise = ext_s_r & ~ext_d_r;
    assign sif.ext_fall = ~ext_s_r & ext_d_r;
    assign sif.run_lvl = run_s_r;

endmodule : hltm_sync

// ==== design/hltm_timer.sv ====
`timescale 1ns/1ps
// How it works
// - Mode 00000 counts while run set, holds otherwise.
// - Count at period returns to zero, continues.
// - Hardware gate: 00001 stops high, 00010 stops low.
// - Edge limit modes reset count on selected edge.
// - Early edge reset restarts PWM two clocks later.
// - Level limit: 00110 resets low, 00111 high.
// - Level limit modes ignore signal while run clear.
// - Level reset acts after two-clock synchroniser delay.
// - Counting resumes after match or released reset level.
// - Software one-shot clears run bit at period match.
// - Software clearing run only pauses one-shot.
// - Edge one-shot starts on selected edge after run.
// - Edge one-shot needs fresh edge after run reset.
// - First edge starts, later edges reset, resume later.
// - Edges ignored while run clear; match ends cycle.
// - Level-reset one-shot holds reset, starts on edge.
// - After run clears, new edge needed to restart.
// - Run bit and signal pass two-stage synchroniser.
// - Software one-shot PWM starts at run, ends at width.
// - Level limit PWM stays high through reset.
// - Level-reset one-shot PWM starts only on edge.
// - Five-bit mode: class upper two, variant lower three.
// - One-shot match clears run and stops at zero.
module hltm_timer (
    input wire logic clk, // System clock, 10 MHz.
    input wire logic rst, // Asynchronous reset, active high.
    input wire logic timer_clock_in, // Timer clock enable pulse after prescaler.
    input wire logic run_set, // Software sets the run bit, one-cycle pulse.
    input wire logic run_clear, // Software clears the run bit, one-cycle pulse.
    input wire logic [hltm_pkg::MODE_W-1:0] mode, // Operating mode field.
    input wire logic [hltm_pkg::CNT_W-1:0] period_value, // Period value.
    input wire logic [hltm_pkg::CNT_W-1:0] pulse_width_value, // PWM pulse width.
    input wire logic ext_reset_signal, // External reset/trigger, asynchronous.
    output logic run_bit, // Run bit as stored.
    output logic [hltm_pkg::CNT_W-1:0] count_value, // Counter value.
    output logic postscaled_match_out, // Period match pulse, one timer clock.
    output logic pwm_drive // Drive for the dependent PWM output.
);

    hltm_sync_if sif ();

    hltm_sync u_sync (
        .clk(clk),
        .rst(rst),
        .tick(timer_clock_in),
        .ext_in(ext_reset_signal),
        .run_in(run_bit),
        .sif(sif.src)
    );

    // ****************************************
    // Edge selection per mode
    // ****************************************
    function automatic logic edge_hit(input hltm_pkg::hltm_class_type cls,
                                      input logic [hltm_pkg::VAR_W-1:0] var_c,
                                      input logic rise,
                                      input logic fall);
        logic rise_en;
        logic fall_en;
        rise_en = 1'b0;
        fall_en = 1'b0;
        if (cls == hltm_pkg::HLTM_CLS_FREE) begin
            rise_en = (var_c == hltm_pkg::VAR_3) || (var_c == hltm_pkg::VAR_4);
            fall_en = (var_c == hltm_pkg::VAR_3) || (var_c == hltm_pkg::VAR_5);
        end else if (cls == hltm_pkg::HLTM_CLS_ONESHOT) begin
            rise_en = (var_c == hltm_pkg::VAR_1) || (var_c == hltm_pkg::VAR_3)
                || (var_c == hltm_pkg::VAR_4) || (var_c == hltm_pkg::VAR_6);
            fall_en = (var_c == hltm_pkg::VAR_2) || (var_c == hltm_pkg::VAR_3)
                || (var_c == hltm_pkg::VAR_5) || (var_c == hltm_pkg::VAR_7);
        end
        edge_hit = (rise & rise_en) | (fall & fall_en);
    endfunction : edge_hit

    hltm_pkg::hltm_class_type cls;
    logic [hltm_pkg::VAR_W-1:0] var_c;
    logic hit;
    logic rst_lvl;
    logic match;

    assign cls = hltm_pkg::hltm_class_type'(mode[hltm_pkg::MODE_W-1:hltm_pkg::CLASS_LSB]);
    assign var_c = mode[hltm_pkg::VAR_W-1:0];
    assign hit = edge_hit(cls, var_c, sif.ext_rise, sif.ext_fall);
    // Variants 110 reset on low, 111 reset on high, in both classes.
    assign rst_lvl = var_c[0];
    assign match = (count_value == period_value);

    logic [hltm_pkg::CNT_W-1:0] cnt_r, cnt_nxt;
    logic [hltm_pkg::HOLD_W-1:0] hold_r, hold_nxt;
    logic armed_r, armed_nxt;
    logic done_r, done_nxt;
    logic run_r, run_nxt;
    logic pwm_r, pwm_nxt;
    logic match_r, match_nxt;
    logic adv;
    logic zero;
    logic hw_clr;
    logic live;

    // ****************************************
    // Counter, start/stop and PWM drive
    // ****************************************
    always_comb begin
        cnt_nxt = cnt_r;
        hold_nxt = hold_r;
        armed_nxt = armed_r;
        done_nxt = done_r;
        pwm_nxt = pwm_r;
        match_nxt = 1'b0;
        adv = 1'b0;
        zero = 1'b0;
        hw_clr = 1'b0;
        // A one-shot cycle may run only until it has completed.
        live = sif.run_lvl & ~done_r;
        if (timer_clock_in) begin
            if (!sif.run_lvl) begin
                armed_nxt = 1'b0;
                done_nxt = 1'b0;
            end
            unique case (cls)
                hltm_pkg::HLTM_CLS_FREE: begin
                    unique case (var_c)
                        hltm_pkg::VAR_0: adv = sif.run_lvl;
                        hltm_pkg::VAR_1: adv = sif.run_lvl & ~sif.ext_lvl;
                        hltm_pkg::VAR_2: adv = sif.run_lvl & sif.ext_lvl;
                        hltm_pkg::VAR_3, hltm_pkg::VAR_4, hltm_pkg::VAR_5: begin
                            if (sif.run_lvl && hit) begin
                                zero = 1'b1;
                            end else begin
                                adv = sif.run_lvl && (hold_r == hltm_pkg::HOLD_NONE);
                            end
                        end
                        hltm_pkg::VAR_6, hltm_pkg::VAR_7: begin
                            if (sif.run_lvl && (sif.ext_lvl == rst_lvl)) begin
                                zero = 1'b1;
                            end else begin
                                adv = sif.run_lvl;
                            end
                        end
                    endcase
                end
                hltm_pkg::HLTM_CLS_ONESHOT: begin
                    unique case (var_c)
                        hltm_pkg::VAR_0: adv = live;
                        hltm_pkg::VAR_1, hltm_pkg::VAR_2, hltm_pkg::VAR_3: begin
                            if (live && hit) begin
                                armed_nxt = 1'b1;
                            end
                            adv = live & armed_r;
                        end
                        hltm_pkg::VAR_4, hltm_pkg::VAR_5: begin
                            if (live && hit) begin
                                if (armed_r) begin
                                    zero = 1'b1;
                                end else begin
                                    armed_nxt = 1'b1;
                                end
                            end
                            adv = live && armed_r && !(hit && armed_r)
                                && (hold_r == hltm_pkg::HOLD_NONE);
                        end
                        hltm_pkg::VAR_6, hltm_pkg::VAR_7: begin
                            if (sif.ext_lvl == rst_lvl) begin
                                zero = 1'b1;
                            end else begin
                                if (live && hit) begin
                                    armed_nxt = 1'b1;
                                end
                                adv = live & armed_r;
                            end
                        end
                    endcase
                end
                default: adv = 1'b0;
            endcase

            if (zero) begin
                cnt_nxt = hltm_pkg::CNT_ZERO;
                hold_nxt = hltm_pkg::HOLD_TICKS;
            end else if (hold_r != hltm_pkg::HOLD_NONE) begin
                hold_nxt = hold_r - hltm_pkg::HOLD_ONE;
            end

            if (adv) begin
                if (match) begin
                    cnt_nxt = hltm_pkg::CNT_ZERO;
                    match_nxt = 1'b1;
                    if (cls == hltm_pkg::HLTM_CLS_ONESHOT) begin
                        hw_clr = 1'b1;
                        done_nxt = 1'b1;
                        armed_nxt = 1'b0;
                    end
                end else begin
                    cnt_nxt = cnt_r + hltm_pkg::CNT_ONE;
                end
                // Drive rises only when a cycle really starts from zero.
                if ((cnt_r == hltm_pkg::CNT_ZERO) && !zero) begin
                    pwm_nxt = 1'b1;
                end
            end
            if (cnt_r == pulse_width_value) begin
                pwm_nxt = 1'b0;
            end
        end
    end

    // ****************************************
    // Run bit: software set wins over any clear
    // ****************************************
    always_comb begin
        run_nxt = run_r;
        if (run_clear || hw_clr) begin
            run_nxt = 1'b0;
        end
        if (run_set) begin
            run_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_r <= hltm_pkg::CNT_ZERO;
            hold_r <= hltm_pkg::HOLD_NONE;
            armed_r <= 1'b0;
            done_r <= 1'b0;
            run_r <= 1'b0;
            pwm_r <= 1'b0;
            match_r <= 1'b0;
        end else begin
            cnt_r <= cnt_nxt;
            hold_r <= hold_nxt;
            armed_r <= armed_nxt;
            done_r <= done_nxt;
            run_r <= run_nxt;
            pwm_r <= pwm_nxt;
            match_r <= match_nxt | (match_r & ~timer_clock_in);
        end
    end

    assign run_bit = run_r;
    assign count_value = cnt_r;
    assign postscaled_match_out = match_r;
    assign pwm_drive = pwm_r;

endmodule : hltm_timer

// ==== testbench/hltm_checker.sv ====
`timescale 1ns/1ps
module hltm_checker (
    input wire logic clk, // Clock.
    input wire logic rst, // Reset.
    input wire logic timer_clock_in, // Tick.
    input wire logic run_set, // Run set.
    input wire logic run_clear, // Run clear.
    input wire logic [hltm_pkg::MODE_W-1:0] mode, // Mode.
    input wire logic [hltm_pkg::CNT_W-1:0] period_value, // Period.
    input wire logic [hltm_pkg::CNT_W-1:0] pulse_width_value, // Width.
    input wire logic ext_reset_signal, // External signal.
    input wire logic run_bit, // Run bit.
    input wire logic [hltm_pkg::CNT_W-1:0] count_value, // Count.
    input wire logic postscaled_match_out, // Match.
    input wire logic pwm_drive // PWM drive.
);
    // ****************
    // Timer properties
    // ****************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);
    chk_count_step: assert property (timer_clock_in |=> $stable(count_value)
        || count_value == 8'h00 || count_value == $past(count_value) + 8'h01) else $error("Bad step.");
    chk_idle_hold: assert property (!timer_clock_in |=> $stable(count_value))
        else $error("Count moved without a tick.");
    chk_period_wrap: assert property (timer_clock_in && count_value == period_value
        |=> count_value == 8'h00 || $stable(count_value)) else $error("No wrap at period.");
    chk_match_zero: assert property ($rose(postscaled_match_out)
        |-> count_value == 8'h00 && $past(count_value) == period_value) else $error("Bad match.");
    chk_run_take: assert property (run_set |=> run_bit)
        else $error("Run bit not set.");
    chk_run_sync: assert property ($rose(run_bit) && !$past(run_bit, 8) && mode == 5'h00
        |-> $stable(count_value)[*3]) else $error("Run bit acted too early.");
    chk_oneshot_end: assert property ($fell(run_bit) && !$past(run_clear) && mode[4:3] == 2'b01
        |-> count_value == 8'h00) else $error("One-shot did not stop at zero.");
    chk_pwm_end: assert property (timer_clock_in && count_value == pulse_width_value
        |=> !pwm_drive) else $error("Drive not ended at width.");
endmodule : hltm_checker
bind hltm_timer hltm_checker u_chk (.clk(clk), .rst(rst), .timer_clock_in(timer_clock_in),
    .run_set(run_set), .run_clear(run_clear), .mode(mode), .period_value(period_value),
    .pulse_width_value(pulse_width_value), .ext_reset_signal(ext_reset_signal),
    .run_bit(run_bit), .count_value(count_value), .postscaled_match_out(postscaled_match_out),
    .pwm_drive(pwm_drive));

// ==== testbench/hltm_trig_src.sv ====
`timescale 1ns/1ps
module hltm_trig_src (
    input wire logic clk, // Clock.
    output logic ext // External reset and trigger signal.
);
    // ************
    // Level driver
    // ************
    time last_change = 0;
    initial ext = 1'b0;
    // Holds each level at least three timer clocks before it may change again.
    task automatic drive(input logic v);
        // Waits in pairs of clocks so the caller keeps its place in the tick rhythm.
        while ($time - last_change < 600) begin
            repeat (2) @(posedge clk);
            #1;
        end
        ext = v;
        last_change = $time;
    endtask : drive
endmodule : hltm_trig_src

// ==== testbench/tb_top.sv ====
`timescale 1ns/1ps
module tb_top;
    logic clk = 1'b0, rst = 1'b1, timer_clock_in = 1'b0;
    logic run_set = 1'b0, run_clear = 1'b0, idle = 1'b0;
    logic [hltm_pkg::MODE_W-1:0] mode = 5'h00;
    logic [hltm_pkg::CNT_W-1:0] period_value = 8'h00, pulse_width_value = 8'h00;
    logic ext_reset_signal, run_bit, postscaled_match_out, pwm_drive;
    logic [hltm_pkg::CNT_W-1:0] count_value;
    int errors = 0, checked = 0;
    always #50 clk = ~clk;
    always @(posedge clk) begin
        #1 timer_clock_in = ~timer_clock_in;
    end
    hltm_timer dut (.clk(clk), .rst(rst), .timer_clock_in(timer_clock_in), .run_set(run_set),
        .run_clear(run_clear), .mode(mode), .period_value(period_value),
        .pulse_width_value(pulse_width_value), .ext_reset_signal(ext_reset_signal),
        .run_bit(run_bit), .count_value(count_value),
        .postscaled_match_out(postscaled_match_out), .pwm_drive(pwm_drive));
    hltm_trig_src src (.clk(clk), .ext(ext_reset_signal));
    // *****
    // Tasks
    // *****
    // Every task spends whole clock pairs, so each returns just after a tick edge.
    task automatic tk(input int n);
        repeat (2 * n) @(posedge clk);
        #1;
    endtask : tk
    task automatic pulse(input logic on);
        run_set = on;
        run_clear = !on;
        @(posedge clk);
        #1 {run_set, run_clear} = 2'b00;
        @(posedge clk);
        #1;
    endtask : pulse
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t ns: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic start(input logic [4:0] m, input logic [7:0] p, input logic [7:0] w,
        input logic lvl);
        rst = 1'b1;
        mode = m;
        period_value = p;
        pulse_width_value = w;
        src.drive(lvl);
        tk(5);
        rst = 1'b0;
        pulse(1'b1);
    endtask : start
    task automatic give_verdict;
        $display("checks %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : give_verdict
    // ********
    // Sequence
    // ********
    initial begin
        start(5'h00, 8'h02, 8'h01, 1'b0);
        tk(1);
        chk(count_value, 8'h00);
        tk(1);
        chk(count_value, 8'h01);
        tk(2);
        chk(count_value, 8'h00);
        chk({7'h00, postscaled_match_out}, 8'h01);
        pulse(1'b0);
        tk(4);
        chk(count_value, 8'h02);
        for (int g = 1; g <= 2; g++) begin
            idle = (g == 2);
            start(5'(g), 8'h10, 8'h00, idle);
            tk(2);
            src.drive(!idle);
            tk(5);
            chk(count_value, 8'h03);
            src.drive(idle);
            tk(3);
            chk(count_value, 8'h04);
        end
        for (int v = 3; v <= 7; v++) begin
            idle = (v == 5 || v == 6);
            start(5'(v), 8'h20, (v < 6) ? 8'h02 : 8'h05, idle);
            tk(2);
            src.drive(!idle);
            tk(4);
            chk(count_value, 8'h00);
            chk({7'h00, pwm_drive}, (v < 6) ? 8'h00 : 8'h01);
            if (v < 6) begin
                tk(1);
                chk({7'h00, pwm_drive}, 8'h01);
                tk(2);
                src.drive(idle);
                tk(4);
                chk(count_value, (v == 3) ? 8'h00 : 8'h07);
            end else begin
                src.drive(idle);
                tk(3);
                chk(count_value, 8'h01);
                pulse(1'b0);
                tk(2);
                src.drive(!idle);
                tk(4);
                chk(count_value, 8'h03);
            end
        end
        start(5'h08, 8'h03, 8'h02, 1'b0);
        tk(2);
        chk({7'h00, pwm_drive}, 8'h01);
        pulse(1'b0);
        tk(2);
        chk(count_value, 8'h03);
        chk({7'h00, pwm_drive}, 8'h00);
        pulse(1'b1);
        tk(2);
        chk(count_value, 8'h00);
        chk({7'h00, run_bit}, 8'h00);
        tk(4);
        chk(count_value, 8'h00);
        pulse(1'b1);
        tk(2);
        chk(count_value, 8'h01);
        for (int v = 1; v <= 5; v++) begin
            idle = (v == 2 || v == 5);
            start({2'b01, 3'(v)}, 8'h20, 8'h00, idle);
            tk(6);
            chk(count_value, 8'h00);
            src.drive(!idle);
            tk(4);
            chk(count_value, 8'h01);
        end
        give_verdict();
    end
endmodule : tb_top
